// ---- logic/sspd_ctrl.sv ----
// Host controller: indirect status write, status lock, deep power-down and resume
`timescale 1ns/10ps
`include "sspd_map.svh"
module sspd_ctrl #(
	parameter int CSH_CYC   = `SSPD_CSH_CYC,
	parameter int SLEEP_CYC = `SSPD_SLEEP_CYC
) (
	// Clock, reset, enable
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CE,
	// Avalon-MM slave
	input  wire logic [2:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// Flash pins
	output logic             SPI_CS_N,
	output logic             SPI_SCK,
	output logic             SPI_SI,
	input  wire logic        SPI_SO
);
	import sspd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	sspd_state_t state, next_state;
	sspd_op_t    op, next_op;
	sspd_frame_t frame, next_frame, built;
	logic        vol, next_vol, step, next_step, kick, next_kick;
	logic [7:0]  reg_addr, next_reg_addr, wdata, next_wdata;
	logic [7:0]  cur_code, next_cur_code, last_code, next_last_code;
	logic [7:0]  rxb, next_rxb;
	logic [2:0]  sent, next_sent;
	logic        asleep, next_asleep, refused, next_refused;
	logic        cs_n, next_cs_n, ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic        spi_start, spi_busy, spi_done, tm_load, tm_expired;
	logic [15:0] tm_count;
	logic [7:0]  spi_rx;
	logic        wr_acc, go, bad_addr;
	sspd_op_t    req_op;

	////////////////////////////////////////////////////////////////////////
	// Frame builder: which bytes go out for a given operation and step
	function automatic sspd_frame_t build_frame(input sspd_op_t o, input logic s, input logic v,
	                                            input logic [7:0] a, input logic [7:0] d);
		sspd_frame_t f;
		f = '{bytes: 32'h0, len: 3'h1};
		case (o)
			SSPD_DO_WRITE: begin
				if (!s) begin
					f.bytes = {v ? `SSPD_OP_VWREN : `SSPD_OP_WREN, 24'h0};
				end else begin
					f = '{bytes: {`SSPD_OP_WSR_IND, a, d, 8'h00}, len: 3'h3};
				end
			end
			SSPD_DO_LOCK: begin
				if (!s) begin
					f.bytes = {`SSPD_OP_WREN, 24'h0};
				end else begin
					f = '{bytes: {`SSPD_OP_LOCK, `SSPD_LOCK_KEY1, `SSPD_LOCK_KEY2, 8'h00}, len: 3'h3};
				end
			end
			SSPD_DO_SLEEP: begin
				if (!s) begin
					f = '{bytes: {`SSPD_OP_RDSR_IND, `SSPD_SR_FIRST, `SSPD_DUMMY, `SSPD_DUMMY}, len: 3'h4};
				end else begin
					f.bytes = {`SSPD_OP_SLEEP, 24'h0};
				end
			end
			SSPD_DO_RESUME: f.bytes = {`SSPD_OP_RESUME, 24'h0};
			SSPD_DO_POLL: f = '{bytes: {`SSPD_OP_RDSR_IND, `SSPD_SR_FIRST, `SSPD_DUMMY, `SSPD_DUMMY}, len: 3'h4};
			default: f = '{bytes: 32'h0, len: 3'h1};
		endcase
		return f;
	endfunction : build_frame

	////////////////////////////////////////////////////////////////////////
	// Submodules
	sspd_spi_byte #(.HALF(`SSPD_SCK_HALF)) u_byte (
		.clk(CORE_CLK), .rst(SYS_RST), .en(CE), .start(spi_start), .tx(frame.bytes[31:24]),
		.rx(spi_rx), .busy(spi_busy), .done(spi_done), .so(SPI_SO), .sck(SPI_SCK), .si(SPI_SI)
	);

	sspd_timer #(.W(16)) u_timer (
		.clk(CORE_CLK), .rst(SYS_RST), .en(CE), .load(tm_load), .count(tm_count), .expired(tm_expired)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode: each access is answered one cycle after it appears
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
	assign wr_acc   = AVS_WRITE & ack;
	assign go       = wr_acc && (AVS_ADDRESS == `SSPD_REG_CTRL);
	assign req_op   = sspd_op_t'(AVS_WRITEDATA[`SSPD_CTRL_OP_HI:0]);
	// Addresses outside the five status registers are never sent; the flash would only abort
	assign bad_addr = (reg_addr < `SSPD_SR_FIRST) || (reg_addr > `SSPD_SR_LAST);
	assign spi_start = (state == SSPD_SHIFT) && kick;
	assign built     = build_frame(op, step, vol, reg_addr, wdata);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for the sequencer and the register file
	always_comb begin
		next_state = state; next_op = op; next_frame = frame; next_vol = vol; next_step = step;
		next_kick = 1'b0; next_reg_addr = reg_addr; next_wdata = wdata; next_cur_code = cur_code;
		next_last_code = last_code; next_rxb = rxb; next_sent = sent; next_asleep = asleep;
		next_refused = refused; next_cs_n = cs_n; tm_load = 1'b0; tm_count = 16'(CSH_CYC);
		next_ack = (AVS_READ | AVS_WRITE) & ~ack;
		next_rdata = 32'h0;
		// Read data is staged in the wait cycle so it stands on the answering edge
		case (AVS_ADDRESS)
			`SSPD_REG_CTRL: next_rdata = {27'h0, vol, 1'b0, op};
			`SSPD_REG_ADDR: next_rdata = {24'h0, reg_addr};
			`SSPD_REG_DATA: next_rdata = {24'h0, wdata};
			`SSPD_REG_STAT: next_rdata = {16'h0, rxb, 5'h0, refused, asleep, state != SSPD_IDLE};
			default:        next_rdata = 32'h0;
		endcase
		if (wr_acc && AVS_ADDRESS == `SSPD_REG_ADDR && state == SSPD_IDLE) begin
			next_reg_addr = AVS_WRITEDATA[7:0];
		end
		if (wr_acc && AVS_ADDRESS == `SSPD_REG_DATA && state == SSPD_IDLE) begin
			next_wdata = AVS_WRITEDATA[7:0];
		end
		// Writing one clears the refused flag; a fresh refusal below still wins
		if (wr_acc && AVS_ADDRESS == `SSPD_REG_STAT && AVS_WRITEDATA[`SSPD_STAT_REFUSED]) begin
			next_refused = 1'b0;
		end
		case (state)
			SSPD_IDLE: begin
				if (go) begin
					// In deep sleep only the resume opcode would be heard
					if ((asleep && req_op != SSPD_DO_RESUME) ||
					    (req_op == SSPD_DO_WRITE && bad_addr) || req_op > SSPD_DO_POLL) begin
						next_refused = 1'b1;
					end else begin
						next_op = req_op; next_vol = AVS_WRITEDATA[`SSPD_CTRL_VOL];
						next_step = 1'b0; next_state = SSPD_LOAD;
					end
				end
			end
			SSPD_LOAD: begin
				next_frame = built; next_cur_code = built.bytes[31:24];
				next_sent = 3'h0; next_cs_n = 1'b0; next_kick = 1'b1; next_state = SSPD_SHIFT;
			end
			SSPD_SHIFT: begin
				if (spi_done) begin
					next_sent = sent + 3'h1;
					next_frame.bytes = {frame.bytes[23:0], 8'h00};
					next_rxb = spi_rx;
					if (sent + 3'h1 == frame.len) begin
						next_cs_n = 1'b1;
						tm_load = 1'b1;
						next_state = SSPD_GAP;
					end else begin
						next_kick = 1'b1;
					end
				end
			end
			SSPD_GAP: begin
				if (tm_expired) begin
					next_last_code = cur_code;
					next_state = SSPD_IDLE;
					case (op)
						SSPD_DO_WRITE, SSPD_DO_LOCK: begin
							if (!step) begin
								next_step = 1'b1; next_state = SSPD_LOAD;
							end
						end
						SSPD_DO_SLEEP: begin
							if (!step) begin
								// Busy flash would drop B9h, so keep polling first
								next_step = !rxb[`SSPD_SR1_BUSY];
								next_state = SSPD_LOAD;
							end else begin
								next_asleep = 1'b1; tm_load = 1'b1; tm_count = 16'(SLEEP_CYC);
								next_state = SSPD_WAIT;
							end
						end
						SSPD_DO_RESUME: begin
							next_asleep = 1'b0; tm_load = 1'b1; tm_count = 16'(SLEEP_CYC);
							next_state = SSPD_WAIT;
						end
						default: next_state = SSPD_IDLE;
					endcase
				end
			end
			SSPD_WAIT: begin
				if (tm_expired) begin
					next_state = SSPD_IDLE;
				end
			end
			default: next_state = SSPD_IDLE;
		endcase
		if (go && state != SSPD_IDLE) begin
			next_refused = 1'b1;
		end
	end

	// Register everything; CE low freezes the whole block
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state <= SSPD_IDLE; op <= SSPD_DO_WRITE; frame <= '0; vol <= 1'b0; step <= 1'b0;
			kick <= 1'b0; reg_addr <= 8'h00; wdata <= 8'h00; cur_code <= 8'h00; last_code <= 8'h00;
			rxb <= 8'h00; sent <= 3'h0; asleep <= 1'b0; refused <= 1'b0; cs_n <= 1'b1;
			ack <= 1'b0; rdata <= 32'h0;
		end else if (CE) begin
			state <= next_state; op <= next_op; frame <= next_frame; vol <= next_vol;
			step <= next_step; kick <= next_kick; reg_addr <= next_reg_addr; wdata <= next_wdata;
			cur_code <= next_cur_code; last_code <= next_last_code; rxb <= next_rxb;
			sent <= next_sent; asleep <= next_asleep; refused <= next_refused; cs_n <= next_cs_n;
			ack <= next_ack; rdata <= next_rdata;
		end
	end

	assign SPI_CS_N     = cs_n;
	assign AVS_READDATA = rdata;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_write_load;
		state == SSPD_LOAD && op == SSPD_DO_WRITE && step;
	endsequence
	sequence s_resume_load;
		state == SSPD_LOAD && op == SSPD_DO_RESUME;
	endsequence

	AST_WRITE_FRAME: assert property (s_write_load |=> frame.bytes[31:8] == {`SSPD_OP_WSR_IND, reg_addr, wdata})
		else $error("indirect write frame wrong");
	AST_NV_WREN: assert property ((s_write_load and !vol) |-> last_code == `SSPD_OP_WREN)
		else $error("nonvolatile write without 06h");
	AST_VOL_WREN: assert property ((s_write_load and vol) |-> last_code == `SSPD_OP_VWREN)
		else $error("volatile write without 50h");
	AST_EACH_WREN: assert property (state == SSPD_LOAD && op == SSPD_DO_WRITE && !step |=>
		frame.bytes[31:24] == (vol ? `SSPD_OP_VWREN : `SSPD_OP_WREN))
		else $error("enable byte missing");
	AST_WRITE_LEN: assert property (s_write_load |=> frame.len == 3'h3)
		else $error("write frame not three bytes");
	AST_WHOLE_FRAME: assert property ($rose(cs_n) |-> sent == frame.len)
		else $error("frame cut short");
	AST_BYTE_EDGE: assert property ($rose(cs_n) |-> !spi_busy && !SPI_SCK)
		else $error("chip select rose mid byte");
	AST_LOCK_WREN: assert property (state == SSPD_LOAD && op == SSPD_DO_LOCK && step |->
		last_code == `SSPD_OP_WREN) else $error("lock without 06h");
	AST_LOCK_KEYS: assert property (state == SSPD_LOAD && op == SSPD_DO_LOCK && step |=>
		frame.bytes[31:8] == {`SSPD_OP_LOCK, `SSPD_LOCK_KEY1, `SSPD_LOCK_KEY2} && frame.len == 3'h3)
		else $error("lock keys wrong");
	AST_IDLE_BEFORE_SLEEP: assert property (state == SSPD_LOAD && op == SSPD_DO_SLEEP && step |->
		!rxb[`SSPD_SR1_BUSY] && last_code == `SSPD_OP_RDSR_IND) else $error("sleep sent while busy");
	AST_POLL_FIRST: assert property (state == SSPD_LOAD && op == SSPD_DO_SLEEP && !step |=>
		frame.bytes[31:16] == {`SSPD_OP_RDSR_IND, `SSPD_SR_FIRST}) else $error("no poll before sleep");
	AST_RESUME_SHORT: assert property (s_resume_load |=> frame.len == 3'h1 && !cs_n)
		else $error("resume frame longer than opcode");
endmodule : sspd_ctrl

// ---- logic/sspd_map.svh ----
// Constants for the status write, lock and power-down SPI controller
// Operation
// - Indirect status write sends 71h, an address byte, then one data byte.
// - A nonvolatile indirect status write is preceded by 06h to set write_permit_latch.
// - A volatile status write is preceded immediately by 50h, good for one write.
// - Every nonvolatile status write gets its own 06h beforehand.
// - Opcode, address and data are eight clocks each, most significant bit first.
// - Clocks 0-7 opcode, 8-15 address, 16-23 data, bit 7 first.
// - The whole sequence is shifted before chip select rises.
// - Chip select rises only on a whole multiple of eight clocks.
// - 06h is issued before the lock opcode.
// - Lock opcode is followed by 4Dh then 67h, nothing else.
// - B9h is ignored while busy; reissue it once the operation finishes.
// - Poll op_in_progress_flag in status one before retrying power-down.
// - ABh then chip select high after clock eight returns the device to standby.
`ifndef SSPD_MAP_SVH
`define SSPD_MAP_SVH
`define SSPD_OP_WREN      8'h06
`define SSPD_OP_VWREN     8'h50
`define SSPD_OP_WSR_IND   8'h71
`define SSPD_OP_LOCK      8'h6f
`define SSPD_LOCK_KEY1    8'h4d
`define SSPD_LOCK_KEY2    8'h67
`define SSPD_OP_SLEEP     8'hb9
`define SSPD_OP_RESUME    8'hab
`define SSPD_OP_RDSR_IND  8'h65
`define SSPD_DUMMY        8'h00
`define SSPD_SR_FIRST     8'h01
`define SSPD_SR_LAST      8'h05
`define SSPD_SR1_BUSY     0
`define SSPD_REG_CTRL     3'h0
`define SSPD_REG_ADDR     3'h1
`define SSPD_REG_DATA     3'h2
`define SSPD_REG_STAT     3'h3
`define SSPD_CTRL_OP_HI   2
`define SSPD_CTRL_VOL     4
`define SSPD_STAT_BUSY    0
`define SSPD_STAT_SLEEP   1
`define SSPD_STAT_REFUSED 2
`define SSPD_STAT_RX_LO   8
`define SSPD_CLK_NS       8
`define SSPD_CSH_NS       50
`define SSPD_CSH_CYC      ((`SSPD_CSH_NS + `SSPD_CLK_NS - 1) / `SSPD_CLK_NS)
`define SSPD_SLEEP_NS     3000
`define SSPD_SLEEP_CYC    ((`SSPD_SLEEP_NS + `SSPD_CLK_NS - 1) / `SSPD_CLK_NS)
`define SSPD_SCK_HALF     2
`endif

// ---- logic/sspd_pkg.sv ----
// Types shared by the status write, lock and power-down controller
package sspd_pkg;
	// Operations that software can start
	typedef enum logic [2:0] {
		SSPD_DO_WRITE  = 3'h0,
		SSPD_DO_LOCK   = 3'h1,
		SSPD_DO_SLEEP  = 3'h2,
		SSPD_DO_RESUME = 3'h3,
		SSPD_DO_POLL   = 3'h4
	} sspd_op_t;
	// Sequencer states, Gray along idle-load-shift-gap-wait
	typedef enum logic [2:0] {
		SSPD_IDLE  = 3'b000,
		SSPD_LOAD  = 3'b001,
		SSPD_SHIFT = 3'b011,
		SSPD_GAP   = 3'b010,
		SSPD_WAIT  = 3'b110
	} sspd_state_t;
	// One chip-select frame: up to four bytes, first in the top lane
	typedef struct packed {
		logic [31:0] bytes;
		logic [2:0]  len;
	} sspd_frame_t;
	// Pins toward the flash
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} sspd_pins_t;
endpackage : sspd_pkg

// ---- logic/sspd_timer.sv ----
// Down counter that paces chip-select gaps and sleep entry
`timescale 1ns/10ps
module sspd_timer #(
	parameter int W = 16
) (
	// Clock and control
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         en,
	// Load and status
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              expired
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	// Load wins over counting so a new gap never merges with an old one
	always_comb begin
		next_cnt = cnt;
		if (load) begin
			next_cnt = count;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
		end else if (en) begin
			cnt <= next_cnt;
		end
	end

	assign expired = (cnt == '0);
endmodule : sspd_timer

// ---- logic/sspd_spi_byte.sv ----
// Mode 0 SPI byte shifter, most significant bit first
`timescale 1ns/10ps
`include "sspd_map.svh"
module sspd_spi_byte #(
	parameter int HALF = `SSPD_SCK_HALF
) (
	// Clock and control
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       en,
	// Byte request and answer
	input  wire logic       start,
	input  wire logic [7:0] tx,
	output logic [7:0]      rx,
	output logic            busy,
	output logic            done,
	// Pins
	input  wire logic       so,
	output logic            sck,
	output logic            si
);
	logic       so_s1, so_s2;
	logic [7:0] sh, next_sh, next_rx, txh, next_txh;
	logic [2:0] k, next_k;
	logic [7:0] cnt, next_cnt;
	logic       next_busy, next_done, next_sck, next_si;
	logic       edge_due;

	assign edge_due = (cnt == 8'(HALF - 1));

	// SCK rises mid-bit for the flash to sample SI; SO is taken just before the fall
	always_comb begin
		next_sh = sh; next_rx = rx; next_txh = txh; next_k = k;
		next_busy = busy; next_done = 1'b0; next_sck = sck; next_si = si;
		next_cnt = cnt;
		if (!busy) begin
			if (start) begin
				next_busy = 1'b1; next_sh = tx; next_txh = tx; next_si = tx[7];
				next_k = 3'h0; next_cnt = 8'h00;
			end
		end else if (!edge_due) begin
			next_cnt = cnt + 8'h01;
		end else begin
			next_cnt = 8'h00;
			if (!sck) begin
				next_sck = 1'b1;
			end else begin
				next_sck = 1'b0;
				next_rx  = {rx[6:0], so_s2};
				next_sh  = {sh[6:0], 1'b0};
				next_si  = sh[6];
				next_k   = k + 3'h1;
				if (k == 3'h7) begin
					next_busy = 1'b0;
					next_done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			so_s1 <= 1'b0; so_s2 <= 1'b0; sh <= 8'h00; rx <= 8'h00; txh <= 8'h00;
			k <= 3'h0; cnt <= 8'h00; busy <= 1'b0; done <= 1'b0; sck <= 1'b0; si <= 1'b0;
		end else if (en) begin
			so_s1 <= so; so_s2 <= so_s1;
			sh <= next_sh; rx <= next_rx; txh <= next_txh; k <= next_k; cnt <= next_cnt;
			busy <= next_busy; done <= next_done; sck <= next_sck; si <= next_si;
		end
	end

	// Each rising SCK carries the next bit of the byte, top bit first
	AST_MSB_FIRST: assert property (@(posedge clk) disable iff (rst)
		$rose(sck) |-> si == txh[3'h7 - k]) else $error("SI bit order wrong");
endmodule : sspd_spi_byte

// ---- tb/sspd_flash_model.sv ----
// Behavioural model of the serial flash status, lock and power-down command logic
`timescale 1ns/10ps
`include "sspd_map.svh"
module sspd_flash_model #(
	parameter int LATCH_BIT   = 1,
	parameter int PSEL_LO_BIT = 7,
	parameter int PSEL_HI_BIT = 0,
	parameter int KIND_BIT    = 7
) (
	// Pins from the host
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	output logic      so
);
	logic [7:0] sr [1:5];
	logic [7:0] b [0:7];
	logic [7:0] sh;
	logic [7:0] rd_v;
	logic       write_permit_latch, vol_ok, locked, deep, deepest;
	int         nbit, busy_left, polls, frames, aborts;

	initial begin
		for (int i = 1; i <= 5; i++) sr[i] = 8'h00;
		{write_permit_latch, vol_ok, locked, deep, deepest, so} = 6'h00;
		nbit = 0;
		busy_left = 0;
		polls = 0;
		frames = 0;
		aborts = 0;
	end

	// Status one carries the live latch and busy flags over the stored bits
	function automatic logic [7:0] cur(input logic [7:0] a);
		logic [7:0] v;
		v = (a >= `SSPD_SR_FIRST && a <= `SSPD_SR_LAST) ? sr[a[2:0]] : 8'h00;
		if (a == 8'h01) begin
			v[LATCH_BIT] = write_permit_latch;
			v[0] = (busy_left != 0);
		end
		return v;
	endfunction : cur

	////////////////////////////////////////////////////////////////////////
	// Shift in on the rising edge, first bit is the most significant
	always @(posedge sck) if (!cs_n) begin
		sh = {sh[6:0], si};
		nbit++;
		if (nbit % 8 == 0 && nbit <= 64) b[nbit/8-1] = sh;
	end

	// Read data leaves on the falling edge so it is settled for the host
	always @(negedge sck) if (!cs_n && b[0] == `SSPD_OP_RDSR_IND && nbit >= 24 && !deep && !deepest) begin
		rd_v = cur(b[1]);
		so <= rd_v[7 - (nbit - 24) % 8];
	end

	always @(negedge cs_n) nbit = 0;

	// Everything acts when the frame closes; a released line shows the inverse
	always @(posedge cs_n) begin
		frames++;
		so <= ~so;
		if (nbit % 8 != 0) aborts++;
		else if (deep || deepest) begin
			if (b[0] == `SSPD_OP_RESUME && nbit == 8) {deep, deepest} = 2'b00;
		end else begin
			case (b[0])
				`SSPD_OP_WREN: if (nbit == 8) write_permit_latch = 1'b1;
				`SSPD_OP_VWREN: vol_ok = 1'b1;
				`SSPD_OP_WSR_IND: begin
					if (nbit == 24 && (write_permit_latch || vol_ok) && !locked && b[1] >= `SSPD_SR_FIRST && b[1] <= `SSPD_SR_LAST)
						sr[b[1][2:0]] = b[2];
					write_permit_latch = 1'b0;
				end
				`SSPD_OP_LOCK: begin
					if (nbit == 24 && write_permit_latch && b[1] == `SSPD_LOCK_KEY1 && b[2] == `SSPD_LOCK_KEY2
						&& sr[1][PSEL_LO_BIT] && sr[2][PSEL_HI_BIT]) locked = 1'b1;
					write_permit_latch = 1'b0;
				end
				`SSPD_OP_SLEEP: if (nbit == 8 && busy_left == 0) begin
					if (sr[4][KIND_BIT]) deep = 1'b1;
					else deepest = 1'b1;
				end
				`SSPD_OP_RDSR_IND: begin
					polls++;
					if (busy_left > 0) busy_left--;
				end
				default: ;
			endcase
			if (b[0] != `SSPD_OP_VWREN) vol_ok = 1'b0;
		end
	end
endmodule : sspd_flash_model

// ---- tb/sspd_ctrl_tb.sv ----
// Self-checking bench for the status write, lock and power-down controller
`timescale 1ns/10ps
module sspd_ctrl_tb;
	logic        CORE_CLK, SYS_RST, CE;
	logic [2:0]  AVS_ADDRESS;
	logic        AVS_READ, AVS_WRITE;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, rdata;
	logic        AVS_WAITREQUEST, SPI_CS_N, SPI_SCK, SPI_SI, SPI_SO;
	int          fails, n_checks, p0;
	logic [7:0]  bad_a [3] = '{8'h00, 8'h06, 8'hff};

	sspd_ctrl #(.SLEEP_CYC(4)) u_sspd_ctrl (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CE(CE),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .SPI_CS_N(SPI_CS_N), .SPI_SCK(SPI_SCK),
		.SPI_SI(SPI_SI), .SPI_SO(SPI_SO));
	sspd_flash_model u_sspd_flash_model (.cs_n(SPI_CS_N), .sck(SPI_SCK), .si(SPI_SI), .so(SPI_SO));

	initial begin
		CORE_CLK = 1'b0;
		forever #4 CORE_CLK = ~CORE_CLK;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One bus cycle; waitrequest and read data are taken at the deciding rising edge
	task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d);
		int n;
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= d;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
		if (n >= 100) begin
			fails++;
			close_out();
		end
		rdata = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		// One idle edge so the next call never reassigns in this time step
		@(posedge CORE_CLK);
	endtask : av

	// Start an operation and wait, bounded, until it is no longer busy
	task automatic run(input logic [2:0] op, input logic vol);
		int k;
		av(1'b1, 3'h0, {27'h0, vol, 1'b0, op});
		k = 0;
		do begin
			av(1'b0, 3'h3, 32'h0);
			k++;
		end while (rdata[0] !== 1'b0 && k < 3000);
		if (k >= 3000) begin
			fails++;
			close_out();
		end
	endtask : run

	task automatic wr_sr(input logic [7:0] a, input logic [7:0] d, input logic vol);
		av(1'b1, 3'h1, {24'h0, a});
		av(1'b1, 3'h2, {24'h0, d});
		run(3'h0, vol);
	endtask : wr_sr

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{SYS_RST, CE, AVS_READ, AVS_WRITE} = 4'b1100;
		{AVS_ADDRESS, AVS_WRITEDATA, fails, n_checks} = '0;
		repeat (4) @(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		@(posedge CORE_CLK);
		check({30'h0, SPI_CS_N, SPI_SCK}, 32'h2);
		wr_sr(8'h03, 8'ha5, 1'b0);
		check({24'h0, u_sspd_flash_model.sr[3]}, 32'ha5);
		check({31'h0, u_sspd_flash_model.write_permit_latch}, 32'h0);
		wr_sr(8'h05, 8'h3c, 1'b1);
		check({24'h0, u_sspd_flash_model.sr[5]}, 32'h3c);
		// Addresses outside the implemented range never reach the pins
		foreach (bad_a[i]) begin
			p0 = u_sspd_flash_model.frames;
			av(1'b1, 3'h1, {24'h0, bad_a[i]});
			av(1'b1, 3'h0, 32'h0);
			av(1'b0, 3'h3, 32'h0);
			check(rdata[2], 1'b1);
			check(u_sspd_flash_model.frames - p0, 0);
			av(1'b1, 3'h3, 32'h4);
		end
		wr_sr(8'h01, 8'h84, 1'b0);
		run(3'h4, 1'b0);
		av(1'b0, 3'h3, 32'h0);
		check(rdata[15:8], 8'h84);
		run(3'h2, 1'b0);
		check({31'h0, u_sspd_flash_model.deepest}, 32'h1);
		run(3'h3, 1'b0);
		check({31'h0, u_sspd_flash_model.deepest}, 32'h0);
		run(3'h1, 1'b0);
		check({31'h0, u_sspd_flash_model.locked}, 32'h0);
		wr_sr(8'h02, 8'h01, 1'b0);
		wr_sr(8'h04, 8'h80, 1'b0);
		run(3'h1, 1'b0);
		check({31'h0, u_sspd_flash_model.locked}, 32'h1);
		check({31'h0, u_sspd_flash_model.write_permit_latch}, 32'h0);
		wr_sr(8'h03, 8'h11, 1'b0);
		check({24'h0, u_sspd_flash_model.sr[3]}, 32'ha5);
		// Busy device: the host must keep polling before power-down
		u_sspd_flash_model.busy_left = 2;
		p0 = u_sspd_flash_model.polls;
		run(3'h2, 1'b0);
		check(u_sspd_flash_model.polls - p0, 3);
		check({31'h0, u_sspd_flash_model.deep}, 32'h1);
		av(1'b1, 3'h0, 32'h0);
		av(1'b0, 3'h3, 32'h0);
		check(rdata[2:1], 2'b11);
		run(3'h3, 1'b0);
		av(1'b0, 3'h3, 32'h0);
		check({rdata[1], u_sspd_flash_model.deep}, 2'b00);
		av(1'b1, 3'h6, 32'hffffffff);
		av(1'b0, 3'h6, 32'h0);
		check(rdata, 32'h0);
		check(u_sspd_flash_model.aborts, 0);
		close_out();
	end
endmodule : sspd_ctrl_tb
